//--- inc/tx_sig_pkg.sv
// constants and register map of the transmit signaling insertion block
// Summary of operation
// R1: E1 CAS alignment byte may come from registers
// R2: E1 enable-1 bit 0 sources upper alignment nibble
// R3: E1 enable-1 bits 1-7 gate channels 1-7
// R4: E1 enable-2 bits 0-7 gate channels 8-15
// R5: E1 enable-3 bit 0 sources lower alignment bits
// R6: E1 enable-3 bits 1-7 gate channels 16-22
// R7: E1 enable-4 bits 0-7 gate channels 23-30
// R8: enable one inserts register signaling, zero passes
// R9: T1 uses three enable registers; fourth ignored
// R10: T1 enable-1 bits gate channels 1-8
// R11: T1 enable-2 bits gate channels 9-16
// R12: T1 enable-3 bits gate channels 17-24
// R13: hardware mode inserts signaling stream into data
// R14: hardware insertion only on selected channels
// R15: insertion works with elastic store on or off
// R16: backplane clock is 1.544 or 2.048 MHz
// R17: software clears common control bit in that case
// R18: source chosen per channel by enable registers
// R19: T1 ESF registers hold one full multiframe
// R20: all enable bits reset to zero
package tx_sig_pkg;
  // register indexes; byte address is four times the index
  localparam logic [5:0] IDX_EN1 = 6'h08;
  localparam logic [5:0] IDX_EN2 = 6'h09;
  localparam logic [5:0] IDX_EN3 = 6'h0a;
  localparam logic [5:0] IDX_EN4 = 6'h0b;
  localparam logic [5:0] IDX_CTRL = 6'h0c;
  localparam logic [5:0] IDX_HWSEL = 6'h0d;
  localparam logic [5:0] IDX_STATUS = 6'h0e;
  localparam logic [7:0] EN_RST = 8'h00;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [31:0] HWSEL_RST = 32'h0000_0000;
  // control register fields
  localparam int CTRL_E1 = 0;
  localparam int CTRL_HW = 1;
  localparam int CTRL_ELASTIC = 2;
  localparam int CTRL_CCR = 3;
  // frame geometry
  localparam logic [7:0] T1_LAST_BIT = 8'hc0;
  localparam logic [7:0] E1_LAST_BIT = 8'hff;
  localparam logic [4:0] T1_LAST_FRAME = 5'h17;
  localparam logic [4:0] E1_LAST_FRAME = 5'h0f;
  localparam logic [4:0] E1_SIG_TS = 5'h10;
  localparam logic [4:0] E1_HI_OFFSET = 5'h0e;
  localparam logic [4:0] T1_SIG_GAP = 5'h06;
  localparam logic [4:0] T1_SIG_PHASE = 5'h05;
  localparam logic [2:0] T1_SIG_BIT = 3'h7;
  localparam logic [2:0] NIB_LO_TOP = 3'h3;
  localparam logic [2:0] NIB_HI_TOP = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- inc/tx_sig_reg_if.sv
// register access carrier between the bus slave and the register file
`timescale 1ns/1ps
interface tx_sig_reg_if;
  logic wr_en;
  logic [5:0] wr_idx;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_hit;
  logic [5:0] rd_idx;
  logic [31:0] rd_data;
  logic rd_hit;
  modport bus (output wr_en, wr_idx, wr_data, wr_strb, rd_idx,
               input wr_hit, rd_data, rd_hit);
  modport regs (input wr_en, wr_idx, wr_data, wr_strb, rd_idx,
                output wr_hit, rd_data, rd_hit);
endinterface

//--- verilog/pin_sync.sv
// two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // pins in, synchronised levels out
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

//--- verilog/axil_reg_slave.sv
// axi4-lite slave front end for the signaling insertion registers
`timescale 1ns/1ps
module axil_reg_slave (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address and data
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read address and data
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // register file side
  tx_sig_reg_if.bus rf
);
  logic aw_full;
  logic w_full;

  assign awready = !aw_full && !bvalid;
  assign wready = !w_full && !bvalid;
  assign arready = !rvalid;
  assign rf.rd_idx = araddr[7:2];
  assign rf.wr_en = aw_full && w_full;

  // address and data may arrive in either order; each is held until both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      rf.wr_idx <= '0;
      rf.wr_data <= '0;
      rf.wr_strb <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_full <= 1'b1;
        rf.wr_idx <= awaddr[7:2];
      end else if (rf.wr_en) begin
        aw_full <= 1'b0;
      end
      if (wvalid && wready) begin
        w_full <= 1'b1;
        rf.wr_data <= wdata;
        rf.wr_strb <= wstrb;
      end else if (rf.wr_en) begin
        w_full <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= tx_sig_pkg::RESP_OKAY;
    end else if (rf.wr_en) begin
      bvalid <= 1'b1;
      bresp <= rf.wr_hit ? tx_sig_pkg::RESP_OKAY : tx_sig_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= tx_sig_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rf.rd_data;
      rresp <= rf.rd_hit ? tx_sig_pkg::RESP_OKAY : tx_sig_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule

//--- verilog/tx_signaling_insert_select.sv
// transmit signaling source selection and insertion, with registers
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module tx_signaling_insert_select (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite register bus
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // transmit signaling registers, byte i at bits 8i+7..8i
  input wire logic [127:0] tx_signaling_regs,
  // backplane pins
  input wire logic tx_backplane_system_clock,
  input wire logic tx_backplane_data_input,
  input wire logic tx_signaling_input,
  input wire logic tx_multiframe_sync,
  // merged stream toward the framer
  output logic tx_data_out,
  output logic tx_sig_inserted
);
  tx_sig_reg_if rf ();

  logic [7:0] sig_insert_enable_1;
  logic [7:0] sig_insert_enable_2;
  logic [7:0] sig_insert_enable_3;
  logic [7:0] sig_insert_enable_4;
  logic [3:0] ctrl;
  logic [31:0] hw_signaling_channel_select;
  logic [3:0] pins;
  logic clk_seen;
  logic bit_edge;
  logic [7:0] bit_cnt;
  logic [4:0] frame_cnt;
  logic locked;
  logic [7:0] pos;
  logic [4:0] fr;
  logic [7:0] last_bit;
  logic [4:0] last_frame;
  logic [7:0] t1_off;
  logic sig_bit;
  logic align;
  logic [4:0] c0;
  logic [1:0] k;
  logic [3:0] reg_idx;
  logic [2:0] bit_sel;
  logic [31:0] en_vec;
  logic sw_bit;
  logic sw_on;
  logic hw_on;
  logic next_data;
  logic e1_mode;
  logic hw_mode;
  logic cfg_conflict;
  logic data_in;
  logic sig_in;
  logic msync;
  logic upper_align_nibble_sel;
  logic lower_align_nibble_sel;

  axil_reg_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .rf(rf.bus)
  );

  // every backplane pin, clock included, runs two flops before use
  pin_sync #(.WIDTH(4)) u_sync (
    .clk(aclk),
    .resetn(aresetn),
    .din({tx_multiframe_sync, tx_signaling_input,
          tx_backplane_data_input, tx_backplane_system_clock}),
    .dout(pins)
  );

  assign e1_mode = ctrl[tx_sig_pkg::CTRL_E1];
  assign hw_mode = ctrl[tx_sig_pkg::CTRL_HW];
  assign data_in = pins[1];
  assign sig_in = pins[2];
  assign msync = pins[3];
  assign upper_align_nibble_sel = sig_insert_enable_1[0];
  assign lower_align_nibble_sel = sig_insert_enable_3[0];
  // insertion does not depend on the elastic store setting [R15]
  // the bad combination is only reported, not corrected [R17]
  assign cfg_conflict = ctrl[tx_sig_pkg::CTRL_ELASTIC] && hw_mode &&
                        ctrl[tx_sig_pkg::CTRL_CCR];

  // register writes; strobes gate the byte lanes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sig_insert_enable_1 <= tx_sig_pkg::EN_RST; // [R20]
      sig_insert_enable_2 <= tx_sig_pkg::EN_RST; // [R20]
      sig_insert_enable_3 <= tx_sig_pkg::EN_RST; // [R20]
      sig_insert_enable_4 <= tx_sig_pkg::EN_RST; // [R20]
      ctrl <= tx_sig_pkg::CTRL_RST;
    end else if (rf.wr_en && rf.wr_strb[0]) begin
      unique case (rf.wr_idx)
        tx_sig_pkg::IDX_EN1: sig_insert_enable_1 <= rf.wr_data[7:0];
        tx_sig_pkg::IDX_EN2: sig_insert_enable_2 <= rf.wr_data[7:0];
        tx_sig_pkg::IDX_EN3: sig_insert_enable_3 <= rf.wr_data[7:0];
        tx_sig_pkg::IDX_EN4: sig_insert_enable_4 <= rf.wr_data[7:0];
        tx_sig_pkg::IDX_CTRL: ctrl <= rf.wr_data[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hw_signaling_channel_select <= tx_sig_pkg::HWSEL_RST;
    end else if (rf.wr_en && rf.wr_idx == tx_sig_pkg::IDX_HWSEL) begin
      for (int i = 0; i < 4; i++) begin
        if (rf.wr_strb[i]) begin
          hw_signaling_channel_select[i*8 +: 8] <= rf.wr_data[i*8 +: 8];
        end
      end
    end
  end

  always_comb begin
    rf.wr_hit = rf.wr_idx inside {tx_sig_pkg::IDX_EN1, tx_sig_pkg::IDX_EN2,
      tx_sig_pkg::IDX_EN3, tx_sig_pkg::IDX_EN4, tx_sig_pkg::IDX_CTRL,
      tx_sig_pkg::IDX_HWSEL};
    rf.rd_hit = 1'b1;
    rf.rd_data = '0;
    unique case (rf.rd_idx)
      tx_sig_pkg::IDX_EN1: rf.rd_data[7:0] = sig_insert_enable_1;
      tx_sig_pkg::IDX_EN2: rf.rd_data[7:0] = sig_insert_enable_2;
      tx_sig_pkg::IDX_EN3: rf.rd_data[7:0] = sig_insert_enable_3;
      tx_sig_pkg::IDX_EN4: rf.rd_data[7:0] = sig_insert_enable_4;
      tx_sig_pkg::IDX_CTRL: rf.rd_data[3:0] = ctrl;
      tx_sig_pkg::IDX_HWSEL: rf.rd_data = hw_signaling_channel_select;
      tx_sig_pkg::IDX_STATUS:
        rf.rd_data[15:0] = {bit_cnt, cfg_conflict, locked, 1'b0, frame_cnt};
      default: rf.rd_hit = 1'b0;
    endcase
  end

  // rising edge of the backplane clock, seen after synchronisation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_seen <= 1'b0;
    end else begin
      clk_seen <= pins[0];
    end
  end
  assign bit_edge = pins[0] && !clk_seen;

  // the multiframe sync marks bit 0 of frame 0 in the bit it flags
  assign pos = msync ? '0 : bit_cnt;
  assign fr = msync ? '0 : frame_cnt;
  assign last_bit = e1_mode ? tx_sig_pkg::E1_LAST_BIT
                            : tx_sig_pkg::T1_LAST_BIT;
  assign last_frame = e1_mode ? tx_sig_pkg::E1_LAST_FRAME
                              : tx_sig_pkg::T1_LAST_FRAME;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_cnt <= '0;
      frame_cnt <= '0;
      locked <= 1'b0;
    end else if (bit_edge) begin
      if (msync) begin
        locked <= 1'b1;
      end
      if (pos >= last_bit) begin
        bit_cnt <= '0;
        frame_cnt <= (fr >= last_frame) ? '0 : fr + 5'h01;
      end else begin
        bit_cnt <= pos + 8'h01;
        frame_cnt <= fr;
      end
    end
  end

  // locate the signaling bit, its channel and its register bit
  always_comb begin
    sig_bit = 1'b0;
    align = 1'b0;
    c0 = '0;
    k = '0;
    t1_off = pos - 8'h01;
    if (e1_mode) begin
      if (pos[7:3] == tx_sig_pkg::E1_SIG_TS) begin
        if (fr == '0) begin
          align = 1'b1; // [R1]
        end else begin
          sig_bit = 1'b1;
          k = pos[1:0];
          c0 = pos[2] ? fr + tx_sig_pkg::E1_HI_OFFSET : fr - 5'h01;
        end
      end
    end else if (pos != '0) begin
      // robbed bit: lsb of each channel in every sixth frame [R19]
      sig_bit = (t1_off[2:0] == tx_sig_pkg::T1_SIG_BIT) &&
                (fr % tx_sig_pkg::T1_SIG_GAP == tx_sig_pkg::T1_SIG_PHASE);
      c0 = t1_off[7:3];
      k = 2'(fr / tx_sig_pkg::T1_SIG_GAP);
    end
  end

  // channel pairs share a register; odd channels use the low nibble
  always_comb begin
    if (align) begin
      reg_idx = '0;
      bit_sel = tx_sig_pkg::NIB_HI_TOP - pos[2:0]; // [R2] [R5]
    end else begin
      reg_idx = e1_mode ? 4'(c0[4:1]) + 4'h1 : 4'(c0[4:1]); // [R19]
      bit_sel = (c0[0] ? tx_sig_pkg::NIB_HI_TOP : tx_sig_pkg::NIB_LO_TOP)
                - 3'(k);
    end
  end

  // per-channel enable vector indexed by channel minus one
  always_comb begin
    if (e1_mode) begin
      en_vec = {2'h0, sig_insert_enable_4, // [R7]
                sig_insert_enable_3[7:1], // [R6]
                sig_insert_enable_2, // [R4]
                sig_insert_enable_1[7:1]}; // [R3]
    end else begin
      // the fourth register plays no part in T1 [R9]
      en_vec = {8'h00, sig_insert_enable_3, // [R12]
                sig_insert_enable_2, // [R11]
                sig_insert_enable_1}; // [R10]
    end
  end

  assign sw_bit = tx_signaling_regs[{reg_idx, bit_sel}];
  // alignment bits in hardware mode come from the registers or the backplane data, never the stream
  assign sw_on = align ? (pos[2] ? lower_align_nibble_sel // [R5]
                                 : upper_align_nibble_sel) // [R2]
                       : sig_bit && en_vec[c0]; // [R8] [R18]
  assign hw_on = sig_bit && hw_mode &&
                 hw_signaling_channel_select[c0]; // [R14]
  // register source wins over the hardware stream for a channel
  assign next_data = sw_on ? sw_bit // [R8]
                   : hw_on ? sig_in // [R13]
                   : data_in;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_data_out <= 1'b0;
      tx_sig_inserted <= 1'b0;
    end else if (bit_edge) begin
      tx_data_out <= next_data; // [R13]
      tx_sig_inserted <= sw_on || hw_on;
    end
  end

  chk_reset_clear: assert property (@(posedge aclk) // [R20]
    !aresetn |=> (sig_insert_enable_1 | sig_insert_enable_2 |
                  sig_insert_enable_3 | sig_insert_enable_4) == 8'h00)
    else $error("enable registers not cleared by reset");

  chk_sw_insert: assert property (@(posedge aclk) // [R8]
    disable iff (!aresetn)
    bit_edge && sig_bit && en_vec[c0] |=> tx_data_out == $past(sw_bit)
      && tx_sig_inserted)
    else $error("register signaling not inserted");

  chk_hw_insert: assert property (@(posedge aclk) // [R13]
    disable iff (!aresetn)
    bit_edge && sig_bit && !en_vec[c0] && hw_mode &&
      hw_signaling_channel_select[c0] |=> tx_data_out == $past(sig_in))
    else $error("hardware signaling not inserted");

  chk_pass_through: assert property (@(posedge aclk) // [R14]
    disable iff (!aresetn)
    bit_edge && !align && !(sig_bit && en_vec[c0]) &&
      !(sig_bit && hw_mode && hw_signaling_channel_select[c0])
      |=> tx_data_out == $past(data_in) && !tx_sig_inserted)
    else $error("unselected bit was altered");

  chk_t1_fourth_reg: assert property (@(posedge aclk) // [R9]
    disable iff (!aresetn)
    !e1_mode |-> en_vec[31:24] == 8'h00)
    else $error("fourth enable register used in T1");

  chk_upper_align: assert property (@(posedge aclk) // [R2]
    disable iff (!aresetn)
    bit_edge && e1_mode && align && !pos[2] && upper_align_nibble_sel
      |=> tx_data_out == $past(tx_signaling_regs[7 - pos[2:0]]))
    else $error("upper alignment nibble not from first register");

  chk_lower_align: assert property (@(posedge aclk) // [R5]
    disable iff (!aresetn)
    bit_edge && e1_mode && align && pos[2] && !lower_align_nibble_sel
      |=> tx_data_out == $past(data_in))
    else $error("lower alignment bits taken without enable");

  chk_t1_sig_frame: assert property (@(posedge aclk) // [R19]
    disable iff (!aresetn)
    !e1_mode && sig_bit |-> fr inside {5'h05, 5'h0b, 5'h11, 5'h17}
      && pos[2:0] == 3'h0)
    else $error("T1 signaling bit outside a signaling frame");

  chk_en1_write: assert property (@(posedge aclk) // [R18]
    disable iff (!aresetn)
    rf.wr_en && rf.wr_strb[0] && rf.wr_idx == tx_sig_pkg::IDX_EN1
      |=> sig_insert_enable_1 == $past(rf.wr_data[7:0]) && bvalid)
    else $error("first enable register not written");

  cov_sw_insert: cover property (@(posedge aclk)
    bit_edge && sw_on && !align);
  cov_hw_insert: cover property (@(posedge aclk)
    bit_edge && hw_on && !sw_on);
  cov_align: cover property (@(posedge aclk)
    bit_edge && align && sw_on);
  cov_t1_wrap: cover property (@(posedge aclk)
    bit_edge && !e1_mode && fr == tx_sig_pkg::T1_LAST_FRAME &&
    pos == tx_sig_pkg::T1_LAST_BIT);
endmodule

//--- testbench/backplane_src.sv
// behavioural backplane source: bit clock, data, signaling and sync
`timescale 1ns/1ps
module backplane_src (
  // control from the bench
  input wire logic run,
  input wire logic e1_mode,
  // backplane pins
  output logic bclk,
  output logic data,
  output logic sig,
  output logic msync,
  // position of the bit now on the pins
  output int bit_pos,
  output int frame
);
  initial begin
    bclk = 1'b0;
    bit_pos = 0;
    frame = 0;
  end
  // clock stands still at multiframe start while run is low
  // the E1 pass runs with the elastic store on, so it needs a standard
  // backplane rate; the T1 pass keeps the elastic store off
  always begin
    if (e1_mode) begin
      #244.140625;
    end else begin
      #200;
    end
    if (!run) begin
      bclk = 1'b0;
      bit_pos = 0;
      frame = 0;
    end else if (!bclk) begin
      bclk = 1'b1;
    end else begin
      bclk = 1'b0;
      // pins move on the falling edge, half a period before use
      if (bit_pos == (e1_mode ? 255 : 192)) begin
        bit_pos = 0;
        frame = (frame == (e1_mode ? 15 : 23)) ? 0 : frame + 1;
      end else begin
        bit_pos = bit_pos + 1;
      end
    end
  end
  assign msync = (bit_pos == 0) && (frame == 0);
  assign data = bit_pos[0] ^ bit_pos[4] ^ frame[0];
  // stream bit always differs from data, so its use is visible
  assign sig = ~data;
endmodule

//--- testbench/tx_signaling_insert_select_tb_top.sv
// self-checking bench for the transmit signaling insertion block
`timescale 1ns/1ps
module tx_signaling_insert_select_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [127:0] tx_signaling_regs = 128'h0;
  logic run = 1'b0, e1_mode = 1'b0;
  logic bclk, bp_data, bp_sig, msync, tx_data_out, tx_sig_inserted;
  int bit_pos, frame;
  int err_count = 0;
  int samples_checked = 0;
  logic [31:0] lfsr = 32'h0000_0062;

  always #25 aclk = ~aclk;

  tx_signaling_insert_select u_tx_signaling_insert_select (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .tx_signaling_regs(tx_signaling_regs),
    .tx_backplane_system_clock(bclk),
    .tx_backplane_data_input(bp_data),
    .tx_signaling_input(bp_sig),
    .tx_multiframe_sync(msync),
    .tx_data_out(tx_data_out),
    .tx_sig_inserted(tx_sig_inserted)
  );

  backplane_src u_backplane_src (
    .run(run), .e1_mode(e1_mode), .bclk(bclk), .data(bp_data),
    .sig(bp_sig), .msync(msync), .bit_pos(bit_pos), .frame(frame)
  );

  function automatic logic [31:0] rnd();
    lfsr = lfsr[0] ? (lfsr >> 1) ^ 32'h8020_0003 : lfsr >> 1;
    return lfsr;
  endfunction

  // returns {inserted, bit} for one position of the multiframe
  function automatic logic [1:0] expect_bit(input int b, input int f,
      input bit e1, input logic [31:0] en, input logic [31:0] hs,
      input logic [127:0] ts, input logic d, input logic s);
    int c, k, sx, byt, sb, ei;
    bit sp, al;
    sp = 0;
    al = 0;
    c = 1;
    sx = 0;
    k = e1 ? b % 8 : (b - 1) % 8;
    if (e1 && b / 8 == 16) begin
      sp = 1;
      al = (f == 0);
      c = al ? 1 : (k < 4 ? f : f + 15);
      sx = k % 4;
    end else if (!e1 && b > 0 && k == 7 && (f + 1) % 6 == 0) begin
      sp = 1;
      c = (b - 1) / 8 + 1;
      sx = (f + 1) / 6 - 1;
    end
    byt = e1 ? (c - 1) / 2 + 1 : (c - 1) / 2;
    sb = (c % 2 ? 3 : 7) - sx;
    ei = e1 ? (c < 16 ? c : c + 1) : c - 1;
    if (al) begin
      byt = 0;
      sb = 7 - k;
      ei = k < 4 ? 0 : 16;
    end
    if (sp && en[ei]) return {1'b1, ts[byt * 8 + sb]};
    // alignment bits never come from the stream
    if (sp && !al && hs[c - 1]) return {1'b1, s};
    return {1'b0, d};
  endfunction

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic give_up;
    err_count++;
    $display("BAD wait expected done seen timeout");
    end_sim();
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] resp);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (n == 200) give_up();
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] resp);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (n == 200) give_up();
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  initial begin
    #4500000;
    give_up();
  end

  initial begin
    logic [31:0] d, en, hs, od, xd, of, xf;
    logic [127:0] ts;
    logic [1:0] r, ex;
    logic [7:0] a;
    int b, f, nbits;
    logic pd, ps;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      axi_read({tx_sig_pkg::IDX_EN1 + 6'(k), 2'b00}, d, r);
      check("enable reset", d, 32'h0);
      check("read resp", 32'(r), 32'(tx_sig_pkg::RESP_OKAY));
    end
    axi_read(8'h3c, d, r);
    check("unmapped data", d, 32'h0);
    check("unmapped resp", 32'(r), 32'(tx_sig_pkg::RESP_SLVERR));
    axi_write({tx_sig_pkg::IDX_STATUS, 2'b00}, rnd(), r);
    check("status write", 32'(r), 32'(tx_sig_pkg::RESP_SLVERR));
    for (int pass = 0; pass < 2; pass++) begin
      en = rnd();
      hs = rnd();
      ts = {rnd(), rnd(), rnd(), rnd()};
      // corner: upper alignment from registers, lower left alone
      if (pass == 1) en = (en | 32'h0000_0001) & 32'hfffe_ffff;
      // common control bit stays clear while elastic and stream are on
      d = pass ? 32'h0000_0007 : 32'h0000_0002;
      axi_write({tx_sig_pkg::IDX_CTRL, 2'b00}, d, r);
      check("ctrl resp", 32'(r), 32'(tx_sig_pkg::RESP_OKAY));
      axi_write({tx_sig_pkg::IDX_HWSEL, 2'b00}, hs, r);
      for (int k = 0; k < 4; k++) begin
        a = {tx_sig_pkg::IDX_EN1 + 6'(k), 2'b00};
        d = rnd();
        d[7:0] = en[8 * k +: 8];
        axi_write(a, d, r);
        axi_read(a, d, r);
        check("enable readback", d, {24'h0, en[8 * k +: 8]});
      end
      tx_signaling_regs <= ts;
      e1_mode <= (pass == 1);
      run <= 1'b1;
      nbits = pass ? 4096 : 4632;
      for (int n = 0; n < nbits; n++) begin
        @(posedge bclk);
        b = bit_pos;
        f = frame;
        pd = bp_data;
        ps = bp_sig;
        repeat (6) @(posedge aclk);
        ex = expect_bit(b, f, pass == 1, en, hs, ts, pd, ps);
        od = 32'(tx_data_out);
        xd = 32'(ex[0]);
        of = 32'(tx_sig_inserted);
        xf = 32'(ex[1]);
        check("inserted flag", of, xf);
        if (pass == 1) begin
          check("e1 bit", od, xd);
        end else begin
          check("t1 bit", od, xd);
        end
      end
      @(posedge aclk);
      run <= 1'b0;
      // a whole multiframe leaves both counters at zero, sync seen
      axi_read({tx_sig_pkg::IDX_STATUS, 2'b00}, d, r);
      check("status", d, 32'h0000_0040);
    end
    end_sim();
  end
endmodule
